// *** hw/gpc_pin_config.sv ***
// twelve general-purpose pins: control registers, output functions, input de-bounce
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
//
// Summary of operation
// - codes Ah/Bh drive external power enables
// - code Ch presents system supply good
// - code Dh converters ok, only ON/SLEEP
// - code Eh outputs synchronous 2 MHz clock
// - clock only while an enable asserted
// - code Fh reset in OFF, SLEEP configurable
// - bit 15 picks input or output set
// - bits 3:0 select function, reset 0000
// - bit 10 clear inverts both directions
// - bit 9 picks CMOS or open drain
// - bits 14:13 pick none/down/up pull
// - pulls on inputs, pull-up on open drain
// - enable clear: high-Z, no pulls
// - bit 12 single or both edge interrupt
// - bit 11 selects I/O supply domain
// - identical control register per pin
// - defaults on reset or map reset
// - ON schedule reloads pins 1 to 6
// - output code 0h drives level bit
// - input level de-bounced, short pulses ignored
module gpc_pin_config
   import gpc_pkg::*;
#(
   parameter int DEB_SHORT_CYCLES = DEB_SHORT_CYC,
   parameter int DEB_LONG_CYCLES  = DEB_LONG_CYC
) (
   input  wire logic                  clk_in,
   input  wire logic                  reset_in,
   input  wire logic                  reg_map_reset_in,
   input  wire logic [ADDR_W-1:0]     addr_in,
   input  wire logic [DATA_W-1:0]     wr_data_in,
   input  wire logic                  wr_strobe_in,
   input  wire logic                  rd_strobe_in,
   output logic      [DATA_W-1:0]     rd_data_out,
   input  wire logic                  reload_strobe_in,
   input  wire gpc_cfg_t [NUM_RELOAD-1:0] reload_cfg_in,
   input  wire gpc_pstate_t           power_state_in,
   input  wire logic                  ext_power_enable_one_in,
   input  wire logic                  ext_power_enable_two_in,
   input  wire logic                  system_supply_ok_in,
   input  wire logic                  converters_ok_in,
   input  wire logic                  converter_clk_2mhz_in,
   input  wire logic                  aux_reset_in_sleep_in,
   input  wire logic [NUM_PINS-1:0]   pin_in,
   output logic      [NUM_PINS-1:0]   pin_out,
   output logic      [NUM_PINS-1:0]   pin_oe_out,
   output logic      [NUM_PINS-1:0]   pull_up_on_out,
   output logic      [NUM_PINS-1:0]   pull_down_on_out,
   output logic      [NUM_PINS-1:0]   io_supply_domain_select_out,
   output logic      [NUM_PINS-1:0]   input_level_out,
   output logic      [NUM_PINS-1:0]   pin_event_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // elaboration checks

   if (DEB_SHORT_CYCLES < 1 || DEB_LONG_CYCLES < 1 ||
       DEB_SHORT_CYCLES >= (1 << DEB_CNT_W) || DEB_LONG_CYCLES >= (1 << DEB_CNT_W)) begin : g_chk
      $error("de-bounce counts must lie in 1 .. 2**DEB_CNT_W-1");
   end

   localparam logic [DEB_CNT_W-1:0] SHORT_LAST = DEB_CNT_W'(DEB_SHORT_CYCLES - 1);
   localparam logic [DEB_CNT_W-1:0] LONG_LAST  = DEB_CNT_W'(DEB_LONG_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // functions

   // raw (pre-polarity) value of an output function
   function automatic logic out_function(input logic [3:0] fn, input logic level_bit);
      logic clk_gate;
      clk_gate = ext_power_enable_one_in | ext_power_enable_two_in;
      unique case (fn)
         FN_GPIO:        out_function = level_bit;
         FN_ON_STATE:    out_function = (power_state_in == GPC_ON);
         FN_SLEEP_STATE: out_function = (power_state_in == GPC_SLEEP);
         FN_EPE_ONE:     out_function = ext_power_enable_one_in;
         FN_EPE_TWO:     out_function = ext_power_enable_two_in;
         FN_SUPPLY_OK:   out_function = system_supply_ok_in;
         FN_CONV_OK:     out_function = converters_ok_in &
                                        (power_state_in == GPC_ON ||
                                         power_state_in == GPC_SLEEP);
         FN_EXT_CLK:     out_function = converter_clk_2mhz_in & clk_gate;
         FN_AUX_RESET:   out_function = (power_state_in == GPC_OFF) |
                                        ((power_state_in == GPC_SLEEP) &
                                         aux_reset_in_sleep_in);
         default:        out_function = 1'b0;
      endcase
   endfunction

   // stored value of a written control word
   function automatic gpc_cfg_t clean_cfg(input logic [DATA_W-1:0] word);
      clean_cfg = gpc_cfg_t'(word & CFG_VALID_MASK);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // control and level registers

   gpc_cfg_t                cfg_reg  [NUM_PINS];
   gpc_cfg_t                cfg_next [NUM_PINS];
   logic     [NUM_PINS-1:0] level_reg;
   logic     [NUM_PINS-1:0] level_next;
   logic                    map_reset;
   gpc_cfg_t [NUM_PINS-1:0] reload_wide;

   assign map_reset = reset_in | reg_map_reset_in;

   // reload words padded to one per pin, so the loop below never indexes past the port
   assign reload_wide = (NUM_PINS*DATA_W)'(reload_cfg_in);

   // reload beats a software write in the same cycle; the sequencer owns pins 1 to 6 then
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         cfg_next[i] = cfg_reg[i];
         if (map_reset) begin
            cfg_next[i] = gpc_cfg_t'(CFG_RESET);
         end else if (reload_strobe_in && i < NUM_RELOAD) begin
            cfg_next[i] = clean_cfg(reload_wide[i]);
         end else if (wr_strobe_in && addr_in == CFG_BASE_ADDR + ADDR_W'(i)) begin
            cfg_next[i] = clean_cfg(wr_data_in);
         end
      end
      level_next = level_reg;
      if (map_reset) begin
         level_next = LEVEL_RESET[NUM_PINS-1:0];
      end else if (wr_strobe_in && addr_in == LEVEL_ADDR) begin
         level_next = wr_data_in[NUM_PINS-1:0];
      end
   end

   always_ff @(posedge clk_in) begin
      for (int i = 0; i < NUM_PINS; i++) begin
         cfg_reg[i] <= cfg_next[i];
      end
      level_reg <= level_next;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin input synchroniser

   logic [NUM_PINS-1:0] sync1_reg;
   logic [NUM_PINS-1:0] sync2_reg;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // per-pin de-bounce, events and pad drive

   logic [DEB_CNT_W-1:0] deb_cnt_reg  [NUM_PINS];
   logic [DEB_CNT_W-1:0] deb_cnt_next [NUM_PINS];
   logic [NUM_PINS-1:0]  deb_lvl_reg;
   logic [NUM_PINS-1:0]  deb_lvl_next;
   logic [NUM_PINS-1:0]  event_next;
   logic [NUM_PINS-1:0]  pin_out_next;
   logic [NUM_PINS-1:0]  pin_oe_next;
   logic [NUM_PINS-1:0]  pu_next;
   logic [NUM_PINS-1:0]  pd_next;
   logic [NUM_PINS-1:0]  read_lvl;

   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         logic                 inv;
         logic                 is_in;
         logic                 ena;
         logic                 val;
         logic                 new_lvl;
         logic [DEB_CNT_W-1:0] last;
         inv     = ~cfg_reg[i].pin_polarity;
         is_in   = cfg_reg[i].pin_direction;
         ena     = cfg_reg[i].pin_drive_on;
         // long filter only for plain level input
         last    = (cfg_reg[i].pin_function_select == FN_GPIO) ? LONG_LAST : SHORT_LAST;
         // new level accepted only after a full stable period
         new_lvl         = deb_lvl_reg[i];
         deb_cnt_next[i] = '0;
         if (!ena) begin
            new_lvl = 1'b0;
         end else if (sync2_reg[i] != deb_lvl_reg[i]) begin
            if (deb_cnt_reg[i] >= last) begin
               new_lvl = sync2_reg[i];
            end else begin
               deb_cnt_next[i] = deb_cnt_reg[i] + DEB_CNT_W'(1);
            end
         end
         deb_lvl_next[i] = new_lvl;
         // single mode fires on the active edge of the polarised level
         event_next[i] = ena & is_in & (new_lvl != deb_lvl_reg[i]) &
                         (cfg_reg[i].edge_interrupt_mode | (new_lvl ^ inv));
         // readback: debounced input, or pad level for an output
         read_lvl[i] = is_in ? (deb_lvl_reg[i] ^ inv) : (sync2_reg[i] ^ inv);
         // output: function value, then polarity, then driver type
         val             = out_function(cfg_reg[i].pin_function_select, level_reg[i]) ^ inv;
         pin_out_next[i] = 1'b0;
         pin_oe_next[i]  = 1'b0;
         if (ena && !is_in) begin
            if (cfg_reg[i].output_drive_type) begin
               pin_oe_next[i] = ~val;
            end else begin
               pin_out_next[i] = val;
               pin_oe_next[i]  = 1'b1;
            end
         end
         // pull-down only on inputs; pull-up also on open-drain outputs
         pd_next[i] = ena & is_in &
                      (cfg_reg[i].pull_resistor_select == PULL_DOWN);
         pu_next[i] = ena & (is_in | cfg_reg[i].output_drive_type) &
                      (cfg_reg[i].pull_resistor_select == PULL_UP);
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            deb_cnt_reg[i] <= '0;
         end
         deb_lvl_reg  <= '0;
         pin_event_out <= '0;
         pin_out      <= '0;
         pin_oe_out   <= '0;
         pull_up_on_out   <= '0;
         pull_down_on_out <= '0;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            deb_cnt_reg[i] <= deb_cnt_next[i];
         end
         deb_lvl_reg      <= deb_lvl_next;
         pin_event_out    <= event_next;
         pin_out          <= pin_out_next;
         pin_oe_out       <= pin_oe_next;
         pull_up_on_out   <= pu_next;
         pull_down_on_out <= pd_next;
      end
   end

   // static per-pin outputs
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         io_supply_domain_select_out[i] = cfg_reg[i].io_supply_domain_select;
         input_level_out[i] = deb_lvl_reg[i] ^ ~cfg_reg[i].pin_polarity;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register read port: data stands one cycle after the strobe, zero otherwise

   logic [DATA_W-1:0] rd_data_next;

   always_comb begin
      rd_data_next = '0;
      if (rd_strobe_in) begin
         if (addr_in == LEVEL_ADDR) begin
            rd_data_next = DATA_W'(read_lvl) & LEVEL_MASK;
         end else if (addr_in >= CFG_BASE_ADDR && addr_in <= CFG_LAST_ADDR) begin
            for (int i = 0; i < NUM_PINS; i++) begin
               if (addr_in == CFG_BASE_ADDR + ADDR_W'(i)) begin
                  rd_data_next = cfg_reg[i];
               end
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rd_data_out <= '0;
      end else begin
         rd_data_out <= rd_data_next;
      end
   end

endmodule

// *** hw/gpc_pkg.sv ***
// package: register map, field layout and timing of the pin configuration block
package gpc_pkg;

   localparam int          NUM_PINS       = 12;
   localparam int          NUM_RELOAD     = 6;
   localparam int          ADDR_W         = 16;
   localparam int          DATA_W         = 16;

   // register addresses, word addressed as printed
   localparam logic [15:0] LEVEL_ADDR     = 16'h400C;
   localparam logic [15:0] CFG_BASE_ADDR  = 16'h4038;
   localparam logic [15:0] CFG_LAST_ADDR  = 16'h4043;

   // field positions of a pin control register
   localparam int          DIR_BIT        = 15;
   localparam int          PULL_MSB       = 14;
   localparam int          PULL_LSB       = 13;
   localparam int          INT_MODE_BIT   = 12;
   localparam int          PWR_DOM_BIT    = 11;
   localparam int          POL_BIT        = 10;
   localparam int          OD_BIT         = 9;
   localparam int          ENA_BIT        = 7;
   localparam int          FN_MSB         = 3;

   // reset values and writable bits
   localparam logic [15:0] CFG_RESET      = 16'hA400;
   localparam logic [15:0] CFG_VALID_MASK = 16'hFE8F;
   localparam logic [15:0] LEVEL_RESET    = 16'h0000;
   localparam logic [15:0] LEVEL_MASK     = 16'h0FFF;

   // function codes (meaning depends on direction)
   localparam logic [3:0]  FN_GPIO        = 4'h0;
   localparam logic [3:0]  FN_ON_STATE    = 4'h2;
   localparam logic [3:0]  FN_SLEEP_STATE = 4'h3;
   localparam logic [3:0]  FN_EPE_ONE     = 4'hA;
   localparam logic [3:0]  FN_EPE_TWO     = 4'hB;
   localparam logic [3:0]  FN_SUPPLY_OK   = 4'hC;
   localparam logic [3:0]  FN_CONV_OK     = 4'hD;
   localparam logic [3:0]  FN_EXT_CLK     = 4'hE;
   localparam logic [3:0]  FN_AUX_RESET   = 4'hF;

   localparam logic [1:0]  PULL_NONE      = 2'h0;
   localparam logic [1:0]  PULL_DOWN      = 2'h1;
   localparam logic [1:0]  PULL_UP        = 2'h2;

   // de-bounce: longest period of each class, as cycles of the 8 ns clock
   localparam int          CLK_PERIOD_NS    = 8;
   localparam int          DEB_SHORT_MAX_US = 64;
   localparam int          DEB_LONG_MAX_MS  = 8;
   localparam int          DEB_SHORT_CYC    = DEB_SHORT_MAX_US * 1000 / CLK_PERIOD_NS;
   localparam int          DEB_LONG_CYC     = DEB_LONG_MAX_MS * 1000000 / CLK_PERIOD_NS;
   localparam int          DEB_CNT_W        = 20;

   typedef struct packed {
      logic       pin_direction;
      logic [1:0] pull_resistor_select;
      logic       edge_interrupt_mode;
      logic       io_supply_domain_select;
      logic       pin_polarity;
      logic       output_drive_type;
      logic       unused_8;
      logic       pin_drive_on;
      logic [2:0] unused_6_4;
      logic [3:0] pin_function_select;
   } gpc_cfg_t;

   typedef enum logic [1:0] {
      GPC_OFF   = 2'b00,
      GPC_ON    = 2'b01,
      GPC_SLEEP = 2'b10
   } gpc_pstate_t;

endpackage

// *** verification/gpc_sva.sv ***
// checker: port-level relations of the pin configuration block
`timescale 1ns/100ps
module gpc_sva
   import gpc_pkg::*;
(
   input  wire logic                clk_in,
   input  wire logic                reset_in,
   input  wire logic                reg_map_reset_in,
   input  wire logic [ADDR_W-1:0]   addr_in,
   input  wire logic [DATA_W-1:0]   wr_data_in,
   input  wire logic                wr_strobe_in,
   input  wire logic                rd_strobe_in,
   input  wire logic [DATA_W-1:0]   rd_data_out,
   input  wire logic                reload_strobe_in,
   input  wire logic [NUM_PINS-1:0] pin_oe_out,
   input  wire logic [NUM_PINS-1:0] pull_up_on_out,
   input  wire logic [NUM_PINS-1:0] pull_down_on_out,
   input  wire logic [NUM_PINS-1:0] io_supply_domain_select_out,
   input  wire logic [NUM_PINS-1:0] pin_event_out
);
   logic [3:0]        idx_q, idx_q2;
   logic [DATA_W-1:0] wd_q, wd_q2;
   logic              cfg_wr;
   logic              in_map;
   ////////////////////////////////////////
   // config write that nothing else overrides in the same cycle
   assign in_map = addr_in >= CFG_BASE_ADDR && addr_in <= CFG_LAST_ADDR;
   assign cfg_wr = wr_strobe_in && in_map && !reload_strobe_in && !reg_map_reset_in;
   // pad outputs lag a write by two edges, so keep index and data that long
   always_ff @(posedge clk_in) begin
      idx_q  <= 4'(addr_in - CFG_BASE_ADDR);
      idx_q2 <= idx_q;
      wd_q   <= wr_data_in;
      wd_q2  <= wd_q;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   sequence quiet_s;
      !wr_strobe_in && !reload_strobe_in && !reg_map_reset_in;
   endsequence
   ////////////////////////////////////////
   chk_rd_idle_zero: assert property (!$past(rd_strobe_in) |-> rd_data_out == '0)
      else $error("read data not zero outside a read");
   chk_rd_unmapped: assert property (rd_strobe_in && !in_map && addr_in != LEVEL_ADDR
      |=> rd_data_out == '0) else $error("unmapped read not zero");
   chk_rd_reserved: assert property (rd_strobe_in && in_map
      |=> (rd_data_out & ~CFG_VALID_MASK) == '0) else $error("undefined config bits set");
   chk_pull_excl: assert property ((pull_up_on_out & pull_down_on_out) == '0)
      else $error("both pulls on");
   chk_pd_input: assert property ((pull_down_on_out & pin_oe_out) == '0)
      else $error("pull-down on a driven pin");
   chk_event_single: assert property ((pin_event_out & $past(pin_event_out)) == '0)
      else $error("event longer than one cycle");
   chk_reset_safe: assert property ($past(reset_in) |-> (pin_oe_out | pull_up_on_out
      | pull_down_on_out) == '0) else $error("pads active after reset");
   chk_map_reset: assert property (reg_map_reset_in ##1 quiet_s |=> (pin_oe_out
      | pull_up_on_out | pull_down_on_out) == '0) else $error("pads active after map reset");
   chk_supply_dom: assert property (cfg_wr
      |=> io_supply_domain_select_out[idx_q] == wd_q[PWR_DOM_BIT]) else $error("domain wrong");
   chk_disable_hiz: assert property (cfg_wr && !wr_data_in[ENA_BIT] ##1 quiet_s
      |=> !pin_oe_out[idx_q2] && !pull_up_on_out[idx_q2] && !pull_down_on_out[idx_q2])
      else $error("disabled pin not high impedance");
   chk_dir_drive: assert property (cfg_wr && wr_data_in[ENA_BIT] && !wr_data_in[OD_BIT]
      ##1 quiet_s |=> pin_oe_out[idx_q2] == !wd_q2[DIR_BIT]) else $error("drive vs direction");
   cov_read: cover property (rd_strobe_in ##1 rd_data_out != '0);
   cov_event: cover property (pin_event_out != '0);
   cov_map_reset: cover property (reg_map_reset_in);
endmodule

// *** verification/gpc_board.sv ***
// board model: pad wire resolution with pulls and an external driver
`timescale 1ns/100ps
module gpc_board
   import gpc_pkg::*;
(
   input  wire logic                clk_in,
   input  wire logic [NUM_PINS-1:0] drv_data_in,
   input  wire logic [NUM_PINS-1:0] drv_oe_in,
   input  wire logic [NUM_PINS-1:0] pull_up_in,
   input  wire logic [NUM_PINS-1:0] pull_down_in,
   input  wire logic [NUM_PINS-1:0] ext_oe_in,
   input  wire logic [NUM_PINS-1:0] ext_data_in,
   output logic      [NUM_PINS-1:0] pad_out
);
   logic [NUM_PINS-1:0] last_q = '0;
   // a floating pad flips every cycle so no stale value can pass as real
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         if (drv_oe_in[i]) pad_out[i] = drv_data_in[i];
         else if (ext_oe_in[i]) pad_out[i] = ext_data_in[i];
         else if (pull_up_in[i]) pad_out[i] = 1'b1;
         else if (pull_down_in[i]) pad_out[i] = 1'b0;
         else pad_out[i] = ~last_q[i];
      end
   end
   // memory of the last pad level
   always @(posedge clk_in) last_q <= pad_out;
endmodule

// *** verification/gpc_pin_config_tb_top.sv ***
// testbench: register, pad, function and input scenarios for the pin block
`timescale 1ns/100ps
module gpc_pin_config_tb_top import gpc_pkg::*;;
   logic                      clk_in = 0, reset_in = 1, map_rst = 0, wr = 0, rd = 0, rl = 0;
   logic [15:0]               addr = 0, wdat = 0, rdat;
   gpc_cfg_t [NUM_RELOAD-1:0] rl_cfg = '0;
   gpc_pstate_t               pstate = GPC_OFF;
   logic                      ext_power_enable_one = 0, ext_power_enable_two = 0, sok = 0, cok = 0, cclk = 0, aux_slp = 0;
   logic [NUM_PINS-1:0]       pin_in, pin_out, oe, pu, pd, dom, lvl, evt, ext_oe = 0, ext_d = 0;
   int                        err_total = 0, cmp_count = 0, cdiv = 0;
   ////////////////////////////////////////
   // 8 ns clock; converter clock near 2 MHz from a divide by 62
   always #4 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cdiv <= cdiv == 30 ? 0 : cdiv + 1;
      if (cdiv == 30) cclk <= ~cclk;
   end
   // short de-bounce counts keep the run brief
   gpc_pin_config #(.DEB_SHORT_CYCLES(4), .DEB_LONG_CYCLES(10)) u_dut (
      .clk_in(clk_in), .reset_in(reset_in), .reg_map_reset_in(map_rst), .addr_in(addr),
      .wr_data_in(wdat), .wr_strobe_in(wr), .rd_strobe_in(rd), .rd_data_out(rdat),
      .reload_strobe_in(rl), .reload_cfg_in(rl_cfg), .power_state_in(pstate),
      .ext_power_enable_one_in(ext_power_enable_one), .ext_power_enable_two_in(ext_power_enable_two),
      .system_supply_ok_in(sok), .converters_ok_in(cok), .converter_clk_2mhz_in(cclk),
      .aux_reset_in_sleep_in(aux_slp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(oe),
      .pull_up_on_out(pu), .pull_down_on_out(pd), .io_supply_domain_select_out(dom),
      .input_level_out(lvl), .pin_event_out(evt));
   gpc_board u_board (.clk_in(clk_in), .drv_data_in(pin_out), .drv_oe_in(oe), .pull_up_in(pu),
      .pull_down_in(pd), .ext_oe_in(ext_oe), .ext_data_in(ext_d), .pad_out(pin_in));
   ////////////////////////////////////////
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(logic [15:0] a, logic [15:0] d);
      @(posedge clk_in);
      wr <= 1'b1;
      addr <= a;
      wdat <= d;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(string n, logic [15:0] a, logic [15:0] e);
      @(posedge clk_in);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_in);
      rd <= 1'b0;
      @(negedge clk_in);
      chk(n, e, rdat);
   endtask
   task automatic settle;
      repeat (4) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   task automatic cfg(int p, logic [15:0] d);
      wr_reg(CFG_BASE_ADDR + 16'(p), d);
      settle();
   endtask
   ////////////////////////////////////////
   task automatic t_regs;
      for (int i = 0; i < NUM_PINS; i++) rd_reg("cfg", CFG_BASE_ADDR + 16'(i), CFG_RESET);
      rd_reg("level", LEVEL_ADDR, 16'h0000);
      rd_reg("low", 16'h4037, 16'h0000);
      rd_reg("high", 16'h4044, 16'h0000);
      chk("pads", 16'h0000, 16'(oe | pu | pd));
      cfg(2, 16'hFFFF);
      rd_reg("cfg3", CFG_BASE_ADDR + 16'd2, 16'hFE8F);
      chk("pull11", 16'h0000, 16'({pu[2], pd[2]}));
      chk("domain", 16'h0001, 16'(dom[2]));
      for (int c = 0; c < 3; c++) begin
         cfg(3, 16'h8080 | 16'(c << 13));
         chk("pull", 16'({c == 2, c == 1}), 16'({pu[3], pd[3]}));
      end
      cfg(3, 16'h4680);
      chk("od_pull", 16'h0002, 16'({pu[3], pd[3]}));
   endtask
   task automatic t_out;
      cfg(4, 16'h0480);
      wr_reg(LEVEL_ADDR, 16'h0010);
      settle();
      chk("gpio", 16'h0003, 16'({pin_out[4], oe[4]}));
      rd_reg("readback", LEVEL_ADDR, 16'h0010);
      cfg(4, 16'h0080);
      chk("inverted", 16'h0001, 16'({pin_out[4], oe[4]}));
      cfg(4, 16'h0680);
      chk("od_high", 16'h0000, 16'({pin_out[4], oe[4]}));
      wr_reg(LEVEL_ADDR, 16'h0000);
      settle();
      chk("od_low", 16'h0001, 16'({pin_out[4], oe[4]}));
   endtask
   task automatic t_funcs;
      logic [3:0] fn [4] = '{4'hA, 4'hB, 4'hC, 4'hD};
      logic       lst;
      int         c;
      for (int r = 0; r < 2; r++) begin
         @(posedge clk_in);
         {ext_power_enable_one, ext_power_enable_two, sok, cok} <= r[0] ? 4'b1010 : 4'b0101;
         pstate <= GPC_ON;
         for (int k = 0; k < 4; k++) begin
            cfg(5, {12'h048, fn[k]});
            chk("fn_out", 16'(r[0] ^ k[0]), 16'(pin_out[5]));
         end
      end
      @(posedge clk_in);
      cok <= 1'b1;
      pstate <= GPC_OFF;
      settle();
      chk("ok_off", 16'h0000, 16'(pin_out[5]));
      cfg(5, 16'h048F);
      for (int s = 0; s < 4; s++) begin
         @(posedge clk_in);
         pstate <= s == 0 ? GPC_OFF : s == 3 ? GPC_ON : GPC_SLEEP;
         aux_slp <= s[0];
         settle();
         chk("aux_reset", 16'(s < 2), 16'(pin_out[5]));
      end
      cfg(5, 16'h008F);
      chk("aux_low", 16'h0001, 16'(pin_out[5]));
      cfg(5, 16'h048E);
      for (int r = 1; r >= 0; r--) begin
         @(posedge clk_in);
         ext_power_enable_one <= r[0];
         ext_power_enable_two <= 1'b0;
         settle();
         lst = pin_out[5];
         c = 0;
         repeat (130) begin
            @(negedge clk_in);
            c += int'(pin_out[5] !== lst);
            lst = pin_out[5];
         end
         chk("clk_gate", 16'h0001, 16'(r ? c >= 4 && c <= 5 : c == 0));
      end
   endtask
   // drive pad 2 and count event pulses while its level settles
   task automatic ev_win(logic [NUM_PINS-1:0] d, int e, logic l);
      int c = 0;
      @(posedge clk_in);
      ext_d <= d;
      repeat (24) begin
         @(negedge clk_in);
         c += int'(evt[1] === 1'b1);
      end
      chk("events", 16'(e), 16'(c));
      chk("level", 16'(l), 16'(lvl[1]));
   endtask
   task automatic t_input;
      ext_oe <= 12'h002;
      cfg(1, 16'h8481);
      ev_win(12'h002, 1, 1);
      rd_reg("in_level", LEVEL_ADDR, 16'h0002);
      ev_win(12'h000, 0, 0);
      @(posedge clk_in);
      ext_d <= 12'h002;
      ev_win(12'h000, 0, 0);
      cfg(1, 16'h9481);
      ev_win(12'h002, 1, 1);
      ev_win(12'h000, 1, 0);
      cfg(1, 16'h8081);
      ev_win(12'h002, 0, 0);
      ev_win(12'h000, 1, 1);
   endtask
   task automatic t_reload;
      cfg(0, 16'h0480);
      cfg(6, 16'h0481);
      @(posedge clk_in);
      rl <= 1'b1;
      rl_cfg[0] <= gpc_cfg_t'(16'h2402);
      rl_cfg[5] <= gpc_cfg_t'(16'h0483);
      @(posedge clk_in);
      rl <= 1'b0;
      rd_reg("pin1", CFG_BASE_ADDR, 16'h2402);
      rd_reg("pin6", CFG_BASE_ADDR + 16'd5, 16'h0483);
      rd_reg("pin7", CFG_BASE_ADDR + 16'd6, 16'h0481);
      @(posedge clk_in);
      map_rst <= 1'b1;
      @(posedge clk_in);
      map_rst <= 1'b0;
      rd_reg("map_rst", CFG_BASE_ADDR + 16'd6, CFG_RESET);
      // analog-input pins: software tri-states them, drive and pulls must go away
      cfg(11, 16'hA480);
      cfg(10, 16'h0480);
      chk("adc_on", 16'h0003, 16'({oe[10], pd[11]}));
      cfg(11, 16'hA400);
      cfg(10, 16'h0400);
      chk("adc_off", 16'h0000, 16'({oe[10], pu[11], pd[11], oe[11]}));
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk_in);
      reset_in <= 1'b0;
      t_regs();
      t_out();
      t_funcs();
      t_input();
      t_reload();
      conclude();
   end
   // hang guard, about twenty-eight times the expected run
   initial begin
      #(8 * 20000);
      err_total++;
      conclude();
   end
endmodule
bind gpc_pin_config gpc_sva u_sva (.clk_in(clk_in), .reset_in(reset_in),
   .reg_map_reset_in(reg_map_reset_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
   .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out),
   .reload_strobe_in(reload_strobe_in), .pin_oe_out(pin_oe_out),
   .pull_up_on_out(pull_up_on_out), .pull_down_on_out(pull_down_on_out),
   .io_supply_domain_select_out(io_supply_domain_select_out), .pin_event_out(pin_event_out));
